// >>> ppmc_top.sv
// Purpose: shared 16-bit counter, control registers and pwm compare modules
// Assumes: all inputs synchronous to ref_clk; sfr port single cycle strobes
// Notes:   read data appear one cycle after sfr_rd
//          hardware flag sets win over a software write in the same cycle
//          slots above NUM_MODULES read as zero and never raise a flag
//          reserved timebase codes stop the count
// Function
// - 8-bit pwm: pin goes high when count low byte equals compare low byte.
// - 8-bit pwm: pin goes low when count low byte overflows.
// - 8-bit pwm: on low byte wrap, compare low byte reloads from compare high byte.
// - 8-bit pwm chosen when compare enable and pwm select are set and wide select is clear.
// - writing compare low clears compare enable; writing compare high sets it.
// - 8-bit high time fraction is (256 minus compare high byte) over 256.
// - 16-bit pwm: high on full count match, low on counter overflow.
// - 16-bit pwm chosen when enable, pwm select and wide select are set.
// - 16-bit high time fraction is (65536 minus compare word) over 65536.
// - three-bit timebase: clk/12, clk/4, timer0, ext falling edges, clk, ext/8.
// - idle halt bit set suspends counting while processor idles.
`timescale 1ns/100ps
`include "ppmc_regs.svh"

module ppmc_top #(
	parameter int NUM_MODULES = 6
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_wr,
	input  wire logic                   sfr_rd,
	input  wire logic [7:0]             sfr_wdata,
	output logic      [7:0]             sfr_rdata,
	input  wire logic                   cpu_idle,
	input  wire logic                   timer0_ovf,
	input  wire logic                   ext_count_in,
	input  wire logic                   ext_osc_in,
	output logic                        irq,
	output logic      [NUM_MODULES-1:0] module_output_pin
);

	// refuse module counts that the six flag bits of the control byte cannot serve
	if (NUM_MODULES < 1 || NUM_MODULES > `PPMC_CTL_FLAGS) begin : g_bad_count
		$error("NUM_MODULES must lie between 1 and 6");
	end

	// whole state in one struct, its next value built by one process
	ppmc_pkg::ppmc_top_state_t s_reg;
	ppmc_pkg::ppmc_top_state_t s_next;

	ppmc_cnt_if cnt_bus ();

	logic [NUM_MODULES-1:0] mode_wr;
	logic [NUM_MODULES-1:0] cmp_lo_wr;
	logic [NUM_MODULES-1:0] cmp_hi_wr;
	logic [NUM_MODULES-1:0] m_match;
	logic [7:0]             m_mode   [NUM_MODULES];
	logic [7:0]             m_cmp_lo [NUM_MODULES];
	logic [7:0]             m_cmp_hi [NUM_MODULES];
	logic                   tick;
	logic                   raw_tick;
	logic                   ext_rise;
	logic [2:0]             tb_sel;
	logic                   run_on;
	logic                   idle_hold;
	logic                   cnt_wrap;
	logic [7:0]             mod_rdata;

	// timebase field and the rising edge of the sampled external oscillator
	assign tb_sel   = s_reg.mode[`PPMC_MD_TB_HI:`PPMC_MD_TB_LO];
	assign ext_rise = ext_osc_in & ~s_reg.ext_q;

	// timebase pick from prescaler and edge detectors
	always_comb begin
		case (tb_sel)
			`PPMC_TB_DIV12: raw_tick = s_reg.pre == `PPMC_DIV12_LAST;
			`PPMC_TB_DIV4:  raw_tick = s_reg.pre == `PPMC_DIV4_LAST;
			`PPMC_TB_T0:    raw_tick = timer0_ovf;
			// falling edge: high on the last clock, low on this one
			`PPMC_TB_ECI:   raw_tick = s_reg.eci_q & ~ext_count_in;
			`PPMC_TB_SYS:   raw_tick = 1'b1;
			// every eighth rising edge of the oscillator
			`PPMC_TB_EXT8:  raw_tick = ext_rise && s_reg.ext_cnt == `PPMC_EXT8_LAST;
			default:        raw_tick = 1'b0; // reserved codes stop the count
		endcase
	end

	assign run_on = s_reg.ctrl[`PPMC_CTL_RUN];
	// idle suspend; the prescaler keeps turning, so the phase after idle is arbitrary
	assign idle_hold = cpu_idle & s_reg.mode[`PPMC_MD_IDLE];
	assign tick      = raw_tick & run_on & ~idle_hold;

	// overflow of the full count, seen only on a counting step
	assign cnt_wrap = tick & (s_reg.cnt == `PPMC_CNT_MAX);

	// shared count to every module; nxt saves each module an adder of its own
	assign cnt_bus.tick = tick;
	assign cnt_bus.cnt  = s_reg.cnt;
	assign cnt_bus.nxt  = s_reg.cnt + 16'h0001;

	// per module write strobes and modules
	for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
		// each slot decodes its own three addresses
		assign mode_wr[i]   = sfr_wr && sfr_addr == `PPMC_ADDR_MMODE + 8'(i);
		assign cmp_lo_wr[i] = sfr_wr && sfr_addr == `PPMC_ADDR_CMP_LO + 8'(i);
		assign cmp_hi_wr[i] = sfr_wr && sfr_addr == `PPMC_ADDR_CMP_HI + 8'(i);
		// one compare module per slot
		ppmc_module u_mod (
			.ref_clk   (ref_clk),
			.rstn      (rstn),
			.cnt_bus   (cnt_bus),
			.mode_wr   (mode_wr[i]),
			.cmp_lo_wr (cmp_lo_wr[i]),
			.cmp_hi_wr (cmp_hi_wr[i]),
			.wdata     (sfr_wdata),
			.mode      (m_mode[i]),
			.cmp_lo    (m_cmp_lo[i]),
			.cmp_hi    (m_cmp_hi[i]),
			.match     (m_match[i]),
			.pin       (module_output_pin[i])
		);
	end

	// counter, registers, flags, read mux and interrupt
	always_comb begin
		logic [3:0] pre_last;
		logic [7:0] flags;
		logic       req;
		pre_last = `PPMC_DIV12_LAST;
		flags    = `PPMC_BYTE_ZERO;
		req      = 1'b0;
		s_next   = s_reg;
		// prescaler runs free; the divide-by-4 choice shortens its loop
		if (tb_sel == `PPMC_TB_DIV4)
			pre_last = `PPMC_DIV4_LAST;
		s_next.pre = (s_reg.pre >= pre_last) ? 4'h0 : s_reg.pre + 4'h1;
		// history for the edge detectors
		s_next.eci_q = ext_count_in;
		s_next.ext_q = ext_osc_in;
		if (ext_rise)
			s_next.ext_cnt = s_reg.ext_cnt + 3'h1;
		// counting step
		if (tick)
			s_next.cnt = cnt_bus.nxt;

		// software writes; a count byte write wins over the step
		if (sfr_wr) begin
			case (sfr_addr)
				`PPMC_ADDR_CTRL:   s_next.ctrl = sfr_wdata;
				`PPMC_ADDR_MODE:   s_next.mode = sfr_wdata;
				`PPMC_ADDR_CNT_LO: s_next.cnt[7:0] = sfr_wdata;
				`PPMC_ADDR_CNT_HI: s_next.cnt[15:8] = sfr_wdata;
				default:           s_next.cnt = s_next.cnt;
			endcase
		end

		// sticky flags, a hardware set beats a same-cycle clear
		if (cnt_wrap)
			s_next.ctrl[`PPMC_CTL_OVF] = 1'b1;
		// match strobes rise on the same edge that steps the count to the compare value, the flag follows a cycle later
		for (int i = 0; i < NUM_MODULES; i++) begin
			if (m_match[i])
				s_next.ctrl[i] = 1'b1;
		end
		// flags of absent modules read zero
		for (int i = NUM_MODULES; i < `PPMC_CTL_FLAGS; i++)
			s_next.ctrl[i] = 1'b0;

		flags = s_reg.ctrl;
		req = flags[`PPMC_CTL_OVF] & s_reg.mode[`PPMC_MD_OVF_IE];
		for (int i = 0; i < NUM_MODULES; i++)
			req = req | (flags[i] & m_mode[i][`PPMC_MM_MIE]);
		s_next.irq = req;

		// read port: low byte read freezes the high byte for a tear-free pair
		if (sfr_rd) begin
			s_next.rdata = `PPMC_BYTE_ZERO;
			case (sfr_addr)
				`PPMC_ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
				`PPMC_ADDR_MODE:   s_next.rdata = s_reg.mode;
				`PPMC_ADDR_CNT_LO: begin
					s_next.rdata   = s_reg.cnt[7:0];
					s_next.snap_hi = s_reg.cnt[15:8];
				end
				// the high byte comes from the snapshot, never the live count
				`PPMC_ADDR_CNT_HI: s_next.rdata = s_reg.snap_hi;
				default:           s_next.rdata = mod_rdata;
			endcase
		end
	end

	// read-back of the module registers; zero where no module owns the address
	always_comb begin
		mod_rdata = `PPMC_BYTE_ZERO;
		for (int i = 0; i < NUM_MODULES; i++) begin
			if (sfr_addr == `PPMC_ADDR_MMODE + 8'(i))
				mod_rdata = m_mode[i];
			if (sfr_addr == `PPMC_ADDR_CMP_LO + 8'(i))
				mod_rdata = m_cmp_lo[i];
			if (sfr_addr == `PPMC_ADDR_CMP_HI + 8'(i))
				mod_rdata = m_cmp_hi[i];
		end
	end

	// state register; every field clears, so the first edge after release
	// sees a stopped array with all pins low
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '{ctrl: `PPMC_CTL_RESET, mode: `PPMC_MD_RESET, cnt: `PPMC_CNT_ZERO,
				snap_hi: `PPMC_BYTE_ZERO, pre: 4'h0, ext_cnt: 3'h0, ext_q: 1'b0,
				eci_q: 1'b0, rdata: `PPMC_BYTE_ZERO, irq: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs come straight from the state flops
	assign sfr_rdata = s_reg.rdata;
	assign irq       = s_reg.irq;

endmodule

// >>> ppmc_regs.svh
// Purpose: address map, bit positions, reset values and timing counts of the pwm counter array
// Assumes: byte wide special function register port
// Notes:   definitions only
`ifndef PPMC_REGS_SVH
`define PPMC_REGS_SVH

// register addresses on the sfr port
`define PPMC_ADDR_CTRL      8'h00
`define PPMC_ADDR_MODE      8'h01
`define PPMC_ADDR_CNT_LO    8'h02
`define PPMC_ADDR_CNT_HI    8'h03
`define PPMC_ADDR_MMODE     8'h10
`define PPMC_ADDR_CMP_LO    8'h18
`define PPMC_ADDR_CMP_HI    8'h20

// array_control_status bits
`define PPMC_CTL_OVF        7
`define PPMC_CTL_RUN        6
`define PPMC_CTL_FLAGS      6
`define PPMC_CTL_RESET      8'h00

// array mode register bits
`define PPMC_MD_IDLE        7
`define PPMC_MD_TB_HI       3
`define PPMC_MD_TB_LO       1
`define PPMC_MD_OVF_IE      0
`define PPMC_MD_RESET       8'h00

// module_mode_reg bits
`define PPMC_MM_WIDE        7
`define PPMC_MM_CEN         6
`define PPMC_MM_PWM         1
`define PPMC_MM_MIE         0
`define PPMC_MM_RESET       8'h00

// timebase codes
`define PPMC_TB_DIV12       3'h0
`define PPMC_TB_DIV4        3'h1
`define PPMC_TB_T0          3'h2
`define PPMC_TB_ECI         3'h3
`define PPMC_TB_SYS         3'h4
`define PPMC_TB_EXT8        3'h5

// divider terminal counts
`define PPMC_DIV12_LAST     4'hb
`define PPMC_DIV4_LAST      4'h3
`define PPMC_EXT8_LAST      3'h7

// counter limits
`define PPMC_LOW_MAX        8'hff
`define PPMC_CNT_MAX        16'hffff
`define PPMC_BYTE_ZERO      8'h00
`define PPMC_CNT_ZERO       16'h0000

`endif

// >>> ppmc_pkg.sv
// Purpose: state types of the pwm counter array
// Assumes: ppmc_regs.svh for the codes
// Notes:   each module keeps its whole state in one of these structs
`include "ppmc_regs.svh"

package ppmc_pkg;

	// state of one compare module
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] cmp_lo;
		logic [7:0] cmp_hi;
		logic       pin;
		logic       match;
	} ppmc_mod_state_t;

	// state of the shared counter and control
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  mode;
		logic [15:0] cnt;
		logic [7:0]  snap_hi;
		logic [3:0]  pre;
		logic [2:0]  ext_cnt;
		logic        ext_q;
		logic        eci_q;
		logic [7:0]  rdata;
		logic        irq;
	} ppmc_top_state_t;

endpackage

// >>> ppmc_cnt_if.sv
// Purpose: carries the shared count and its step enable to every compare module
// Assumes: driven combinationally by the top
// Notes:   nxt is cnt plus one, valid while tick is high
`timescale 1ns/100ps

interface ppmc_cnt_if;
	logic        tick;
	logic [15:0] cnt;
	logic [15:0] nxt;

	modport drv (output tick, output cnt, output nxt);
	modport mdl (input tick, input cnt, input nxt);
endinterface

// >>> ppmc_module.sv
// Purpose: one capture/compare module in 8-bit or 16-bit pwm mode
// Assumes: count steps only while cnt_bus.tick is high
// Notes:   other compare modes hold the pin low
`timescale 1ns/100ps
`include "ppmc_regs.svh"

module ppmc_module (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	ppmc_cnt_if.mdl         cnt_bus,
	input  wire logic       mode_wr,
	input  wire logic       cmp_lo_wr,
	input  wire logic       cmp_hi_wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] mode,
	output logic      [7:0] cmp_lo,
	output logic      [7:0] cmp_hi,
	output logic            match,
	output logic            pin
);

	ppmc_pkg::ppmc_mod_state_t s_reg;
	ppmc_pkg::ppmc_mod_state_t s_next;

	// mode decode and next state
	always_comb begin
		logic       pwm8;
		logic       pwm16;
		logic       low_ovf;
		logic       hit;
		logic [7:0] ref_lo;
		pwm8    = 1'b0;
		pwm16   = 1'b0;
		low_ovf = 1'b0;
		hit     = 1'b0;
		ref_lo  = s_reg.cmp_lo;
		s_next  = s_reg;
		s_next.match = 1'b0;
		pwm8  = s_reg.mode[`PPMC_MM_CEN] & s_reg.mode[`PPMC_MM_PWM] & ~s_reg.mode[`PPMC_MM_WIDE];
		pwm16 = s_reg.mode[`PPMC_MM_CEN] & s_reg.mode[`PPMC_MM_PWM] & s_reg.mode[`PPMC_MM_WIDE];
		low_ovf = cnt_bus.cnt[7:0] == `PPMC_LOW_MAX;
		if (pwm8 && cnt_bus.tick) begin
			// reload on wrap: the reloaded value is compared at once, so zero gives full duty
			if (low_ovf) begin
				ref_lo = s_reg.cmp_hi;
				s_next.cmp_lo = s_reg.cmp_hi;
			end
			hit = cnt_bus.nxt[7:0] == ref_lo;
			// high from match, low at wrap
			if (hit)
				s_next.pin = 1'b1;
			else if (low_ovf)
				s_next.pin = 1'b0;
		end else if (pwm16 && cnt_bus.tick) begin
			hit = cnt_bus.nxt == {s_reg.cmp_hi, s_reg.cmp_lo};
			// high from match, low at overflow
			if (hit)
				s_next.pin = 1'b1;
			else if (cnt_bus.cnt == `PPMC_CNT_MAX)
				s_next.pin = 1'b0;
		end else if (!pwm8 && !pwm16) begin
			s_next.pin = 1'b0;
		end
		s_next.match = hit;
		// software writes come last so they win over a reload in the same cycle
		if (mode_wr)
			s_next.mode = wdata;
		if (cmp_lo_wr) begin
			s_next.cmp_lo = wdata;
			s_next.mode[`PPMC_MM_CEN] = 1'b0;
		end
		if (cmp_hi_wr) begin
			s_next.cmp_hi = wdata;
			s_next.mode[`PPMC_MM_CEN] = 1'b1;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '{mode: `PPMC_MM_RESET, cmp_lo: `PPMC_BYTE_ZERO, cmp_hi: `PPMC_BYTE_ZERO,
				pin: 1'b0, match: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign mode   = s_reg.mode;
	assign cmp_lo = s_reg.cmp_lo;
	assign cmp_hi = s_reg.cmp_hi;
	assign match  = s_reg.match;
	assign pin    = s_reg.pin;

endmodule

// >>> ppmc_load_model.sv
// Purpose: load on one pwm pin that totals its high clocks
// Assumes: pin sampled on ref_clk
// Notes:   clr restarts the total
`timescale 1ns/100ps

module ppmc_load_model (
	input  wire logic        ref_clk,
	input  wire logic        pin,
	input  wire logic        clr,
	output logic      [16:0] high_cnt
);
	// a plain tally, so one window gives the high time directly
	always @(posedge ref_clk) begin
		high_cnt <= clr ? 17'h00000 : high_cnt + {16'h0000, pin};
	end
endmodule

// >>> ppmc_top_chk.sv
// Purpose: port checks of the pwm counter array
// Assumes: ticks are gated only by run and idle halt
// Notes:   mirrors a few written control bits
`timescale 1ns/100ps

module ppmc_top_chk #(
	parameter int NUM_MODULES = 6
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_wr,
	input  wire logic                   sfr_rd,
	input  wire logic [7:0]             sfr_wdata,
	input  wire logic [7:0]             sfr_rdata,
	input  wire logic                   cpu_idle,
	input  wire logic                   timer0_ovf,
	input  wire logic                   ext_count_in,
	input  wire logic                   ext_osc_in,
	input  wire logic                   irq,
	input  wire logic [NUM_MODULES-1:0] module_output_pin
);
	logic run_reg;
	logic halt_reg;
	logic pwm_reg;

	// software written bits only; hardware never changes them
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			run_reg <= 1'b0;
			halt_reg <= 1'b0;
			pwm_reg <= 1'b0;
		end else if (sfr_wr) begin
			if (sfr_addr == 8'h00) run_reg <= sfr_wdata[6];
			if (sfr_addr == 8'h01) halt_reg <= sfr_wdata[7];
			if (sfr_addr == 8'h10) pwm_reg <= sfr_wdata[1];
		end
	end

	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'hff |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	// three quiet cycles so a late mode write cannot move the pin
	a_stop_holds: assert property ((!run_reg && !sfr_wr)[*3] |-> $stable(module_output_pin))
		else $error("pins moved while stopped");
	a_low_clears: assert property ((sfr_wr && sfr_addr == 8'h18) ##1
		(sfr_rd && sfr_addr == 8'h10) |=> !sfr_rdata[6])
		else $error("enable not cleared by low write");
	a_high_sets: assert property ((sfr_wr && sfr_addr == 8'h20) ##1
		(sfr_rd && sfr_addr == 8'h10) |=> sfr_rdata[6])
		else $error("enable not set by high write");
	a_idle_freezes: assert property ((halt_reg && cpu_idle && !sfr_wr)[*3] |->
		$stable(module_output_pin))
		else $error("pins moved during idle halt");
	a_off_low: assert property ((!pwm_reg)[*2] |-> !module_output_pin[0])
		else $error("pin high outside pwm mode");
	a_rise_pwm: assert property ($rose(module_output_pin[0]) |-> $past(pwm_reg))
		else $error("pin rose outside pwm mode");

	c_pin_rise: cover property ($rose(module_output_pin[0]));
	c_irq_rise: cover property ($rose(irq));
	c_idle_halt: cover property (halt_reg && cpu_idle);
endmodule

// >>> ppmc_top_bench.sv
// Purpose: bench for the pwm counter array
// Assumes: load model on pin 0; ticks as the timebase says
// Notes:   expected results wait in a queue for the monitor
`timescale 1ns/100ps

module ppmc_top_bench;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic        cpu_idle = 1'b0;
	logic        irq;
	logic [5:0]  pins;
	logic        clr = 1'b0;
	logic [1:0]  meas = 2'h0;
	logic [16:0] high_cnt;
	logic [33:0] expq[$];
	logic [33:0] e;
	logic [16:0] got;
	logic [7:0]  hi;
	logic [2:0]  ext_in = 3'h0;
	logic [2:0]  tbs[7] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h2, 3'h3, 3'h5};
	logic [7:0]  exps[7] = '{8'h04, 8'h0c, 8'h30, 8'h00, 8'h10, 8'h10, 8'h02};
	int          n_errors = 0;
	int          check_count = 0;

	ppmc_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
		.timer0_ovf(ext_in[0]), .ext_count_in(ext_in[1]), .ext_osc_in(ext_in[2]), .irq(irq),
		.module_output_pin(pins));
	ppmc_load_model i_load (.ref_clk(ref_clk), .pin(pins[0]), .clr(clr), .high_cnt(high_cnt));

	always #12.5 ref_clk = ~ref_clk;

	task automatic check(input logic [16:0] g, input logic [16:0] x);
		check_count++;
		if (g !== x) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask

	// strobes are left up so transfers can run back to back
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
		@(posedge ref_clk);
		#2;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
		expq.push_back({9'h000, m, 9'h000, v});
		bus(1'b0, a, 8'h00);
	endtask

	task automatic idle(input int n);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		repeat (n) @(posedge ref_clk);
		#2;
	endtask

	// window of n clocks; the monitor samples the tally after the last one
	task automatic measure(input int n, input logic [16:0] v);
		clr = 1'b1;
		idle(1);
		clr = 1'b0;
		repeat (n - 1) @(posedge ref_clk);
		#2;
		expq.push_back({17'h1ffff, v});
		meas = 2'h1;
		idle(1);
		meas = 2'h0;
	endtask

	// irq together with the pins of the unused slots, which must stay low
	task automatic irq_is(input logic v);
		expq.push_back({17'h0003f, 11'h000, 5'h00, v});
		meas = 2'h2;
		idle(1);
		meas = 2'h0;
	endtask

	// takes the oldest note whenever a result shows up
	always @(posedge ref_clk) begin
		#1;
		if (sfr_rd || meas != 2'h0) begin
			e = expq.size() > 0 ? expq.pop_front() : {17'h1ffff, 17'h1ffff};
			got = meas == 2'h1 ? high_cnt :
				meas == 2'h2 ? {11'h000, pins[5:1], irq} : {9'h000, sfr_rdata};
			check(got & e[33:17], e[16:0]);
		end
	end

	task automatic report_and_stop;
		if (expq.size() > 0) begin
			n_errors++;
			$display("unexpected at %0t: %0d notes never checked", $time, expq.size());
		end
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		hi = 8'($urandom(25));
		repeat (6) @(posedge ref_clk);
		#2;
		rstn = 1'b1;
		idle(1);
		rd(8'h00, 8'hff, 8'h00);
		rd(8'hff, 8'hff, 8'h00);
		rd(8'h01, 8'hff, 8'h00);
		$display("test reset done");
		wr(8'h10, 8'h42);
		wr(8'h18, 8'h40);
		rd(8'h10, 8'hff, 8'h02);
		wr(8'h20, hi);
		rd(8'h10, 8'hff, 8'h42);
		$display("test enable done");
		// the free-running prescaler gives a fixed tick count per 48 clocks
		// pin-fed timebases get sixteen pulses, each one clock high in four
		for (int i = 0; i < 7; i++) begin
			wr(8'h01, {4'h0, tbs[i], 1'b0});
			wr(8'h02, 8'h00);
			wr(8'h00, 8'h40);
			if (i < 4) begin
				idle(47);
			end else begin
				repeat (16) begin
					ext_in[i-4] = 1'b1;
					idle(1);
					ext_in[i-4] = 1'b0;
					idle(3);
				end
			end
			wr(8'h00, 8'h00);
			rd(8'h02, 8'hff, exps[i]);
		end
		$display("test timebase done");
		wr(8'h01, 8'h08);
		wr(8'h00, 8'h40);
		idle(300);
		measure(256, 17'h00100 - {9'h000, hi});
		rd(8'h18, 8'hff, hi);
		$display("test pwm8 done");
		wr(8'h00, 8'h00);
		wr(8'h02, 8'h20);
		idle(20);
		rd(8'h02, 8'hff, 8'h20);
		cpu_idle = 1'b1;
		wr(8'h01, 8'h88);
		wr(8'h00, 8'h40);
		idle(20);
		rd(8'h02, 8'hff, 8'h20);
		cpu_idle = 1'b0;
		$display("test halt done");
		wr(8'h00, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h18, 8'hf0);
		wr(8'h20, 8'hff);
		wr(8'h02, 8'h00);
		wr(8'h03, 8'hff);
		wr(8'h01, 8'h09);
		wr(8'h10, 8'hc2);
		wr(8'h00, 8'h40);
		measure(400, 17'h00010);
		rd(8'h00, 8'hc1, 8'hc1);
		irq_is(1'b1);
		// the match has been seen, so a new compare word may go in, low byte first
		wr(8'h18, 8'hf0);
		wr(8'h20, 8'hff);
		rd(8'h10, 8'hff, 8'hc2);
		wr(8'h00, 8'h40);
		idle(3);
		irq_is(1'b0);
		rd(8'h00, 8'hc1, 8'h40);
		$display("test pwm16 done");
		report_and_stop();
	end
endmodule

bind ppmc_top ppmc_top_chk #(.NUM_MODULES(NUM_MODULES)) i_chk (.ref_clk(ref_clk),
	.rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
	.timer0_ovf(timer0_ovf), .ext_count_in(ext_count_in), .ext_osc_in(ext_osc_in),
	.irq(irq), .module_output_pin(module_output_pin));
